/* File: inc/esmc_defs.vh */
// Constants for the enable and sleep mode controller
`ifndef ESMC_DEFS_VH
`define ESMC_DEFS_VH
`define ESMC_CLK_HZ 20000000
`define ESMC_HZ_PER_MHZ 1000000
`define ESMC_ENTRY_US 1000
`define ESMC_WAKE_US 250
`define ESMC_CNT_W 15
`define ESMC_ST_RUN 2'h0
`define ESMC_ST_LOW 2'h1
`define ESMC_ST_STBY 2'h2
`define ESMC_ST_SLEEP 2'h3
`define ESMC_PHASES 3
`endif

/* File: rtl/esmc_top.v */
// Enable, sleep mode and fault clear controller for a three phase gate driver
`timescale 1ns/10ps
`include "esmc_defs.vh"
module esmc_top #(
  parameter PHASES = `ESMC_PHASES,
  parameter CNT_W = `ESMC_CNT_W,
  parameter ENTRY_CYC = (`ESMC_ENTRY_US * (`ESMC_CLK_HZ / `ESMC_HZ_PER_MHZ)),
  parameter WAKE_CYC = (`ESMC_WAKE_US * (`ESMC_CLK_HZ / `ESMC_HZ_PER_MHZ)),
  parameter TRANSLATOR_VARIANT = 1
) (
  input wire core_clk_in,
  input wire rstn_in,
  input wire chip_enable_in,
  input wire [PHASES-1:0] low_side_pwm_in,
  input wire [PHASES-1:0] high_side_pwm_in,
  input wire sleep_select_in,
  input wire current_limit_trip_in,
  input wire [PHASES-1:0] gate_fault_in,
  input wire supervisor_fault_in,
  output wire [PHASES-1:0] low_side_gate_out,
  output wire [PHASES-1:0] high_side_gate_out,
  output reg current_limit_fault_out,
  output reg supervisor_fault_out,
  output reg amp_enable_out,
  output reg reg12_enable_out,
  output reg reg5_enable_out,
  output reg buck_enable_out,
  output reg monitor_enable_out,
  output reg standby_out,
  output reg sleep_out,
  output reg fault_latched_out
);
  localparam [CNT_W-1:0] ENTRY_LIM = ENTRY_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] WAKE_LIM = WAKE_CYC[CNT_W-1:0];
  localparam [1:0] ST_RUN = `ESMC_ST_RUN;
  localparam [1:0] ST_LOW = `ESMC_ST_LOW;
  localparam [1:0] ST_STBY = `ESMC_ST_STBY;
  localparam [1:0] ST_SLEEP = `ESMC_ST_SLEEP;
  // Pin bundle, low bits first: low pwm, high pwm, faults, select, trip, supervisor
  localparam PIN_W = 3 * PHASES + 3;

  reg ce_s1_q, ce_s2_q, ce_s3_q, ce_q;
  reg [1:0] st_q, st_d;
  reg [CNT_W-1:0] cnt_q;
  reg wake_ok_q;

  wire [PIN_W-1:0] pin_raw;
  wire [PIN_W-1:0] pin_flt;
  wire [PHASES-1:0] ph_fault;
  assign pin_raw = {supervisor_fault_in, current_limit_trip_in, sleep_select_in,
                    gate_fault_in, high_side_pwm_in, low_side_pwm_in};

  wire [PHASES-1:0] lo_f = pin_flt[PHASES-1:0];
  wire [PHASES-1:0] hi_f = pin_flt[2*PHASES-1:PHASES];
  wire [PHASES-1:0] gf_f = pin_flt[3*PHASES-1:2*PHASES];
  wire sel_f = pin_flt[3*PHASES];
  wire trip_f = pin_flt[3*PHASES+1];
  wire sup_f = pin_flt[3*PHASES+2];

  wire fault_now = |gf_f;
  wire fault_any = |ph_fault;
  wire ce_rise = ce_s2_q & ce_s3_q & ~ce_q;
  wire ce_fall = ~ce_s2_q & ~ce_s3_q & ce_q;

  wire nxt_run = (st_d == ST_RUN);
  wire nxt_low = (st_d == ST_LOW);
  wire nxt_stby = (st_d == ST_STBY);
  wire nxt_sleep = (st_d == ST_SLEEP);

  // Enable synchroniser stages
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ce_s1_q <= 1'b0;
      ce_s2_q <= 1'b0;
      ce_s3_q <= 1'b0;
    end else begin
      ce_s1_q <= chip_enable_in;
      ce_s2_q <= ce_s1_q;
      ce_s3_q <= ce_s2_q;
    end
  end

  // Filtered level, changes once stages two and three agree
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ce_q <= 1'b0;
    end else begin
      if (ce_s2_q == ce_s3_q) begin
        ce_q <= ce_s2_q;
      end
    end
  end

  // Other pins filtered alike; costs a few cycles of PWM latency
  genvar b;
  generate
    for (b = 0; b < PIN_W; b = b + 1) begin : g_pin
      reg s1_q, s2_q, s3_q, lvl_q;
      always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          lvl_q <= 1'b0;
        end else begin
          s1_q <= pin_raw[b];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            lvl_q <= s2_q;
          end
        end
      end
      assign pin_flt[b] = lvl_q;
    end
  endgenerate

  // Low time counter cleared at each rise, saturates
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q <= {CNT_W{1'b0}};
    end else begin
      if (ce_q | ce_rise) begin
        cnt_q <= {CNT_W{1'b0}};
      end else if (cnt_q != ENTRY_LIM) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // Wake qualifier, set once the low time is long enough
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wake_ok_q <= 1'b0;
    end else begin
      if (ce_rise | ce_q) begin
        wake_ok_q <= 1'b0;
      end else if (cnt_q >= WAKE_LIM - 1'b1) begin
        wake_ok_q <= 1'b1;
      end
    end
  end

  always @* begin
    st_d = st_q;
    case (st_q)
      ST_RUN: begin
        if (ce_fall) begin
          st_d = ST_LOW;
        end
      end
      ST_LOW: begin
        if (ce_rise) begin
          st_d = ST_RUN; // Short pulse, fault clear only
        end else if (cnt_q == ENTRY_LIM - 1'b1) begin
          st_d = sel_f ? ST_SLEEP : ST_STBY;
        end
      end
      ST_STBY: begin
        if (ce_rise) begin
          st_d = ST_RUN;
        end
      end
      ST_SLEEP: begin
        if (ce_rise & wake_ok_q) begin
          st_d = ST_RUN;
        end
      end
      default: begin
        st_d = ST_RUN;
      end
    endcase
  end

  // Qualifying state after reset, so a low pin still reaches low power
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= ST_LOW;
    end else begin
      st_q <= st_d;
    end
  end

  // Per phase fault latch; a fault still present wins over the clearing edge
  genvar p;
  generate
    for (p = 0; p < PHASES; p = p + 1) begin : g_flt
      reg lat_q;
      always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          lat_q <= 1'b0;
        end else begin
          if (gf_f[p]) begin
            lat_q <= 1'b1;
          end else if (ce_rise) begin
            lat_q <= 1'b0;
          end
        end
      end
      assign ph_fault[p] = lat_q;
    end
  endgenerate

  // Raw enable gates the drivers so the turn-off needs no clock edge
  wire drive_ok = chip_enable_in & ce_q & (st_q == ST_RUN) & ~fault_any;

  // Dead time relies on host waveforms; shoot-through pair is still blocked
  genvar g;
  generate
    for (g = 0; g < PHASES; g = g + 1) begin : g_ph
      wire lo_on = lo_f[g] & ~hi_f[g];
      wire hi_on = hi_f[g] & ~lo_f[g];
      assign low_side_gate_out[g] = drive_ok & lo_on;
      assign high_side_gate_out[g] = drive_ok & hi_on;
    end
  endgenerate

  // Active low while trip or fault persists
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      current_limit_fault_out <= 1'b1;
    end else begin
      current_limit_fault_out <= ~(trip_f | fault_now | fault_any);
    end
  end

  // Supervisor keeps reporting in Standby, silent in Sleep
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      supervisor_fault_out <= 1'b1;
    end else begin
      supervisor_fault_out <= ~(sup_f & ~nxt_sleep);
    end
  end

  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      amp_enable_out <= 1'b0;
    end else begin
      amp_enable_out <= nxt_run | nxt_low;
    end
  end

  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg12_enable_out <= 1'b0;
    end else begin
      reg12_enable_out <= nxt_run | nxt_low;
    end
  end

  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg5_enable_out <= 1'b0;
    end else begin
      reg5_enable_out <= ~nxt_sleep & ((TRANSLATOR_VARIANT == 0) | ~nxt_stby);
    end
  end

  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      buck_enable_out <= 1'b0;
    end else begin
      buck_enable_out <= ~nxt_sleep;
    end
  end

  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      monitor_enable_out <= 1'b0;
    end else begin
      monitor_enable_out <= ~nxt_sleep;
    end
  end

  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      standby_out <= 1'b0;
    end else begin
      standby_out <= nxt_stby;
    end
  end

  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sleep_out <= 1'b0;
    end else begin
      sleep_out <= nxt_sleep;
    end
  end

  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fault_latched_out <= 1'b0;
    end else begin
      fault_latched_out <= fault_any | fault_now;
    end
  end

endmodule

/* File: test/esmc_host.sv */
// Host model driving enable and PWM
`timescale 1ns/10ps
module esmc_host (
  input wire core_clk_in,
  output logic chip_enable_out = 1'b1,
  output logic [2:0] lo_out = 3'h0,
  output logic [2:0] hi_out = 3'h0);
  // One idle cycle between patterns: dead time is ours
  task automatic pwm(input logic [2:0] l, input logic [2:0] h);
    @(posedge core_clk_in) #1 {lo_out, hi_out} = 6'h00;
    @(posedge core_clk_in) #1 {lo_out, hi_out} = {l, h};
  endtask
  task automatic ce_pulse(input int n);
    @(posedge core_clk_in) #1 chip_enable_out = 1'b0;
    repeat (n) @(posedge core_clk_in);
    #1 chip_enable_out = 1'b1;
  endtask
endmodule

/* File: test/esmc_props.sv */
// Checker for the enable and sleep controller
`timescale 1ns/10ps
module esmc_props #(parameter ENTRY_CYC = 40) (
  input wire core_clk_in,
  input wire rstn_in,
  input wire chip_enable_in,
  input wire sleep_select_in,
  input wire current_limit_trip_in,
  input wire [2:0] low_side_gate_out,
  input wire [2:0] high_side_gate_out,
  input wire current_limit_fault_out,
  input wire amp_enable_out,
  input wire reg12_enable_out,
  input wire reg5_enable_out,
  input wire standby_out,
  input wire sleep_out,
  input wire fault_latched_out);
  logic [15:0] lo_q;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  // Raw low time, so entry cannot sneak in early
  always @(posedge core_clk_in or negedge rstn_in)
    if (!rstn_in) lo_q <= 16'h0;
    else lo_q <= chip_enable_in ? 16'h0 : lo_q + 16'h1;
  sequence s_lp; $rose(standby_out | sleep_out); endsequence
  sequence s_up; chip_enable_in [*6] ##0 !sleep_out; endsequence
  AST_GATE_OFF: assert property (!chip_enable_in |->
    !(low_side_gate_out | high_side_gate_out)) else $error("gate on");
  AST_ENTRY_LATE: assert property (s_lp |-> lo_q >= ENTRY_CYC - 1)
    else $error("early entry");
  AST_MODE_PICK: assert property (s_lp |-> sleep_out == sleep_select_in)
    else $error("wrong mode");
  AST_LP_LOW: assert property (s_lp |-> !chip_enable_in) else $error("entry");
  AST_STBY_OFF: assert property (standby_out |-> !amp_enable_out &&
    !reg12_enable_out && !reg5_enable_out) else $error("standby on");
  AST_RUN_ON: assert property (s_up |-> amp_enable_out && reg12_enable_out)
    else $error("run off");
  AST_TRIP: assert property (current_limit_trip_in [*3] |->
    ##[1:4] !current_limit_fault_out) else $error("trip");
  AST_FAULT_HOLD: assert property (fault_latched_out |-> !current_limit_fault_out)
    else $error("fault");
endmodule

/* File: test/tb_esmc_top.sv */
// Bench for the enable and sleep controller
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t %h %h", $time, a, e); end end
module tb_esmc_top;
  logic clk = 0, rstn = 0, sel = 0, trip = 0, sup = 0;
  logic [2:0] gflt = 3'h0;
  wire ce;
  wire [2:0] lo, hi, gl, gh;
  wire clf, sfo, amp, r12, r5, bk, mon, stb, slp, flt;
  int n_fail = 0, compares = 0, cyc = 0;
  esmc_top #(.ENTRY_CYC(40), .WAKE_CYC(10)) dut (.core_clk_in(clk), .rstn_in(rstn),
    .chip_enable_in(ce), .low_side_pwm_in(lo), .high_side_pwm_in(hi), .sleep_select_in(sel),
    .current_limit_trip_in(trip), .gate_fault_in(gflt), .supervisor_fault_in(sup),
    .low_side_gate_out(gl), .high_side_gate_out(gh), .current_limit_fault_out(clf),
    .supervisor_fault_out(sfo), .amp_enable_out(amp), .reg12_enable_out(r12),
    .reg5_enable_out(r5), .buck_enable_out(bk), .monitor_enable_out(mon),
    .standby_out(stb), .sleep_out(slp), .fault_latched_out(flt));
  esmc_host host (.core_clk_in(clk), .chip_enable_out(ce), .lo_out(lo), .hi_out(hi));
  initial forever #25 clk = ~clk;
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_pwm;
    host.pwm(3'h5, 3'h2);
    wt(5);
    `CHK({gl, gh}, 6'h2a)
    fork host.ce_pulse(20); begin wt(2); `CHK({gl, gh}, 6'h00) end join
    wt(8);
    `CHK({stb, gh}, 4'h2)
  endtask
  task automatic t_fault;
    for (int k = 1; k >= 0; k--) begin
      @(posedge clk) #1 {trip, gflt} = 4'hc;
      wt(3);
      {trip, gflt} = {2'h0, k[0], 1'h0};
      host.ce_pulse(20);
      wt(8);
      `CHK(clf, ~k[0])
      `CHK(flt, k[0])
    end
  endtask
  task automatic t_lp;
    sup = 1'b1;
    for (int s = 0; s < 2; s++) begin
      sel = s[0];
      fork
        host.ce_pulse(60);
        begin
          wt(50);
          `CHK({slp, amp, r12, bk, mon, r5, sfo},
            {s[0], 2'h0, ~s[0], ~s[0], 1'b0, s[0]})
        end
      join
      wt(8);
      `CHK({slp, sfo}, 2'h0)
    end
    sup = 1'b0;
    host.ce_pulse(20);
    wt(8);
    `CHK({slp, stb, amp}, 3'h1)
  endtask
  task automatic final_report;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) if (++cyc == 2000) begin n_fail++; final_report; end
  initial begin
    wt(12);
    rstn = 1;
    wt(4);
    t_pwm;
    t_fault;
    t_lp;
    final_report;
  end
endmodule
bind esmc_top esmc_props #(.ENTRY_CYC(ENTRY_CYC)) chk (.*);
